// ---- core/adcc_pkg.sv ----
// Constants shared by the converter control block: register map,
// field positions, reset values, modes and bus answers.
// Assumes a 32-bit AXI4-Lite slave port with a 16-bit byte address.
package adcc_pkg;
	// ==========================================================
	// Register indexes; byte address is four times the index
	localparam logic [15:0] IDX_SC1 = 16'h0010;
	localparam logic [15:0] IDX_SC2 = 16'h0011;
	localparam logic [15:0] IDX_SC3 = 16'h0012;
	localparam logic [15:0] IDX_SC4 = 16'h0013;
	localparam logic [15:0] IDX_RH = 16'h0014;
	localparam logic [15:0] IDX_RL = 16'h0015;
	localparam logic [15:0] IDX_CVH = 16'h0016;
	localparam logic [15:0] IDX_CVL = 16'h0017;
	localparam logic [15:0] IDX_PC1 = 16'h30ac;
	localparam logic [15:0] IDX_PC2 = 16'h30ad;
	localparam logic [15:0] ADDR_SC1 = {IDX_SC1[13:0], 2'b00};
	localparam logic [15:0] ADDR_SC2 = {IDX_SC2[13:0], 2'b00};
	localparam logic [15:0] ADDR_SC3 = {IDX_SC3[13:0], 2'b00};
	localparam logic [15:0] ADDR_SC4 = {IDX_SC4[13:0], 2'b00};
	localparam logic [15:0] ADDR_RH = {IDX_RH[13:0], 2'b00};
	localparam logic [15:0] ADDR_RL = {IDX_RL[13:0], 2'b00};
	localparam logic [15:0] ADDR_CVH = {IDX_CVH[13:0], 2'b00};
	localparam logic [15:0] ADDR_CVL = {IDX_CVL[13:0], 2'b00};
	localparam logic [15:0] ADDR_PC1 = {IDX_PC1[13:0], 2'b00};
	localparam logic [15:0] ADDR_PC2 = {IDX_PC2[13:0], 2'b00};
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_SC1 = 8'h1f;
	localparam logic [7:0] RST_SC2 = 8'h08;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// ==========================================================
	// Field positions
	localparam int SC1_DONE = 7;
	localparam int SC1_IEN = 6;
	localparam int SC1_CONT = 5;
	localparam int SC2_ACTIVE = 7;
	localparam int SC2_HWT = 6;
	localparam int SC2_CMP = 5;
	localparam int SC2_GE = 4;
	localparam int SC3_LP = 7;
	localparam int SC3_DIV = 5;
	localparam int SC3_LSMP = 4;
	localparam int SC3_MODE = 2;
	localparam int SC3_CLK = 0;
	localparam logic [4:0] CH_STOP = 5'h1f;
	// ==========================================================
	// Resolution modes and bus answers
	localparam logic [1:0] MODE_8 = 2'h0;
	localparam logic [1:0] MODE_12 = 2'h1;
	localparam logic [1:0] MODE_10 = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_NEXT = 2'b11
	} adcc_state_type;
endpackage : adcc_pkg

// ---- core/adcc_top.sv ----
// Converter control: register file on AXI4-Lite, channel queue,
// result queue, trigger and compare logic around an analog core.
// Assumes the core converts on a one-cycle start and answers with a
// one-cycle done carrying a 12-bit code, MSB aligned.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Contract
// R1 - Control write aborts and restarts, except 0x1F
// R2 - Queued channels converted in written order
// R3 - Queue mode waits for programmed depth
// R4 - Writing 0x1F flushes queue, stops conversion
// R5 - Right-justified unsigned 8, 10, 12 bits
// R6 - Single returns idle, continuous keeps converting
// R7 - Result queue up to eight, selectable depth
// R8 - Compare less-than or greater-equal, may interrupt
// R9 - Completion flag with interrupt request
// R10 - Software or hardware trigger selectable
// R11 - Conversion clock from four sources
// R12 - Route selected input of 24 to converter
// R13 - Sample time and speed/power configurable
// R14 - Keeps converting in wait and stop3
// R15 - Flag per conversion, compare hit, or set
// R16 - Flag clears on control write, low read
// R17 - Interrupt when flag set and enabled
// R18 - Trigger starts one set or looping sets
module adcc_top #(
	parameter int QUEUE_MAX = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog core
	output logic conv_start,
	output logic conv_abort,
	output logic [4:0] conv_channel,
	output logic [1:0] conv_resolution,
	output logic [1:0] conv_clock_select,
	output logic [1:0] conv_clock_div,
	output logic conv_long_sample,
	output logic conv_low_power,
	input wire logic conv_done,
	input wire logic [11:0] conv_data,
	// Trigger, interrupt, pin control
	input wire logic hw_trigger_input,
	output logic done_irq,
	output logic [15:0] pin_enable
);
	import adcc_pkg::*;

	// ==========================================================
	// Declarations
	adcc_state_type state_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [15:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic ien_q;
	logic cont_q;
	logic [4:0] ch_q;
	logic [6:0] sc2_q;
	logic [7:0] sc3_q;
	logic [2:0] depth_q;
	logic [3:0] cvh_q;
	logic [7:0] cvl_q;
	logic [7:0] pc1_q;
	logic [7:0] pc2_q;
	logic done_q;
	logic [4:0] chq_q [QUEUE_MAX];
	logic [11:0] res_q [QUEUE_MAX];
	logic [3:0] chq_cnt_q;
	logic [2:0] idx_q;
	logic [2:0] rd_q;
	logic hit_q;
	logic start_q;
	logic abort_q;
	logic [4:0] chan_q;
	logic trig_s1_q;
	logic trig_s2_q;
	logic trig_s3_q;
	logic wr_go;
	logic wr_ok;
	logic sc1_wr;
	logic stop_wr;
	logic rd_go;
	logic rl_read;
	logic [31:0] rd_mux;
	logic rd_ok;
	logic queue_on;
	logic [3:0] set_len;
	logic sw_trig;
	logic hw_trig;
	logic trig;
	logic take_done;
	logic last;
	logic [11:0] res_fmt;
	logic [11:0] cmp_val;
	logic cmp_ok;
	logic flag_set;
	logic [4:0] first_ch;

	// ==========================================================
	// Result formatting
	// Core code is MSB aligned; shift down so the LSB lands in bit 0
	function automatic logic [11:0] adcc_fmt(input logic [11:0] d,
			input logic [1:0] mode);
		case (mode)
			MODE_8: adcc_fmt = {4'h0, d[11:4]};
			MODE_10: adcc_fmt = {2'h0, d[11:2]};
			default: adcc_fmt = d;
		endcase
	endfunction : adcc_fmt

	// ==========================================================
	// AXI4-Lite write path
	// Address and data are caught independently, in either order
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;

	// Write decode; only byte lane 0 carries register data
	always_comb begin
		case (aw_addr_q)
			ADDR_SC1, ADDR_SC2, ADDR_SC3, ADDR_SC4, ADDR_RH, ADDR_RL,
			ADDR_CVH, ADDR_CVL, ADDR_PC1, ADDR_PC2: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	assign sc1_wr = wr_go && w_strb_q && (aw_addr_q == ADDR_SC1);
	assign stop_wr = sc1_wr && (w_data_q[4:0] == CH_STOP);

	// Holding registers and the write answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 16'h0000;
			w_data_q <= 8'h00;
			w_strb_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata[7:0];
				w_strb_q <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rl_read = rd_go && (s_axi_araddr == ADDR_RL);

	// Read mux; result bytes show the head of the result queue
	always_comb begin
		rd_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			ADDR_SC1: rd_mux[7:0] = {done_q, ien_q, cont_q, ch_q};
			ADDR_SC2: rd_mux[7:0] = {state_q != ST_IDLE, sc2_q};
			ADDR_SC3: rd_mux[7:0] = sc3_q;
			ADDR_SC4: rd_mux[7:0] = {5'h00, depth_q};
			ADDR_RH: rd_mux[7:0] = {4'h0, res_q[rd_q][11:8]};
			ADDR_RL: rd_mux[7:0] = res_q[rd_q][7:0];
			ADDR_CVH: rd_mux[7:0] = {4'h0, cvh_q};
			ADDR_CVL: rd_mux[7:0] = cvl_q;
			ADDR_PC1: rd_mux[7:0] = pc1_q;
			ADDR_PC2: rd_mux[7:0] = pc2_q;
			default: rd_ok = 1'b0;
		endcase
	end

	// Read answer, one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ien_q <= RST_SC1[SC1_IEN];
			cont_q <= RST_SC1[SC1_CONT];
			ch_q <= RST_SC1[4:0];
			sc2_q <= RST_SC2[6:0];
			sc3_q <= RST_ZERO;
			depth_q <= RST_ZERO[2:0];
			cvh_q <= RST_ZERO[3:0];
			cvl_q <= RST_ZERO;
			pc1_q <= RST_ZERO;
			pc2_q <= RST_ZERO;
		end else if (wr_go && w_strb_q) begin
			case (aw_addr_q)
				ADDR_SC1: begin
					ien_q <= w_data_q[SC1_IEN];
					cont_q <= w_data_q[SC1_CONT];
					ch_q <= w_data_q[4:0];
				end
				ADDR_SC2: sc2_q <= w_data_q[6:0];
				ADDR_SC3: sc3_q <= w_data_q; // see R11 R13
				ADDR_SC4: depth_q <= w_data_q[2:0]; // see R7
				ADDR_CVH: cvh_q <= w_data_q[3:0];
				ADDR_CVL: cvl_q <= w_data_q;
				ADDR_PC1: pc1_q <= w_data_q;
				ADDR_PC2: pc2_q <= w_data_q;
				default: ;
			endcase
		end
	end

	// Static controls to the analog core and pads
	assign conv_clock_select = sc3_q[SC3_CLK+:2]; // see R11
	assign conv_clock_div = sc3_q[SC3_DIV+:2]; // see R13
	assign conv_long_sample = sc3_q[SC3_LSMP]; // see R13
	assign conv_low_power = sc3_q[SC3_LP]; // see R13
	assign conv_resolution = sc3_q[SC3_MODE+:2]; // see R5
	assign pin_enable = {pc2_q, pc1_q};

	// ==========================================================
	// Hardware trigger synchroniser
	// The trigger is asynchronous; a rise is found by comparing the second and third stages
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
		end else begin
			trig_s1_q <= hw_trigger_input;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	// ==========================================================
	// Trigger decisions
	// Depth field zero means no queue; n means n+1 entries
	assign queue_on = (depth_q != 3'h0);
	assign set_len = {1'b0, depth_q} + 4'h1;
	assign sw_trig = sc1_wr && !stop_wr && !sc2_q[SC2_HWT] &&
		(!queue_on || (chq_cnt_q + 4'h1 == set_len)); // see R1 R3
	assign hw_trig = trig_s2_q && !trig_s3_q && sc2_q[SC2_HWT] &&
		!sc1_wr && (state_q == ST_IDLE) &&
		(!queue_on || (chq_cnt_q == set_len)); // see R10 R3
	assign trig = sw_trig || hw_trig;
	// A control write kills the conversion, so its done is dropped
	assign take_done = conv_done && !sc1_wr &&
		(state_q == ST_BUSY);
	assign last = !queue_on || ({1'b0, idx_q} + 4'h1 == set_len);
	// Channel of a fresh set; a written channel wins outside queues
	assign first_ch = queue_on ? chq_q[0] :
		(sc1_wr ? w_data_q[4:0] : ch_q); // see R12

	// ==========================================================
	// Compare and completion flag
	assign res_fmt = adcc_fmt(conv_data, conv_resolution); // see R5
	assign cmp_val = {cvh_q, cvl_q};
	assign cmp_ok = sc2_q[SC2_GE] ? (res_fmt >= cmp_val) :
		(res_fmt < cmp_val); // see R8
	always_comb begin
		flag_set = 1'b0;
		if (take_done && last) begin
			if (!sc2_q[SC2_CMP]) begin
				flag_set = 1'b1; // see R15
			end else begin
				flag_set = cmp_ok || (queue_on && hit_q); // see R15 R8
			end
		end
	end

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_q <= RST_SC1[SC1_DONE];
		end else if (flag_set) begin
			done_q <= 1'b1; // see R9
		end else if (sc1_wr || rl_read) begin
			done_q <= 1'b0; // see R16
		end
	end

	// Level request; stays up until the flag is cleared
	assign done_irq = done_q && ien_q; // see R17 R8

	// ==========================================================
	// Channel queue
	// Entries are kept after a set so continuous mode can loop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chq_cnt_q <= 4'h0;
		end else if (stop_wr) begin
			chq_cnt_q <= 4'h0; // see R4
		end else if (wr_go && w_strb_q && aw_addr_q == ADDR_SC4) begin
			chq_cnt_q <= 4'h0;
		end else if (sc1_wr && queue_on && chq_cnt_q < set_len) begin
			chq_cnt_q <= chq_cnt_q + 4'h1; // see R2
		end
	end

	// Queue storage, one entry per slot
	for (genvar i = 0; i < QUEUE_MAX; i++) begin : g_entry
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				chq_q[i] <= RST_ZERO[4:0];
				res_q[i] <= 12'h000;
			end else begin
				if (sc1_wr && !stop_wr && queue_on &&
						chq_cnt_q == 4'(i)) begin
					chq_q[i] <= w_data_q[4:0]; // see R2
				end
				if (take_done && idx_q == 3'(i)) begin
					res_q[i] <= res_fmt; // see R7
				end
			end
		end
	end

	// Result read pointer; reading the low byte moves to the next
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q <= 3'h0;
		end else if (trig || (take_done && last && cont_q)) begin
			rd_q <= 3'h0;
		end else if (rl_read && queue_on &&
				({1'b0, rd_q} + 4'h1 < set_len)) begin
			rd_q <= rd_q + 3'h1; // see R7
		end
	end

	// ==========================================================
	// Conversion sequencer
	// No low-power input gates this logic, so wait and stop3 keep it
	// running from whichever clock the core is given; see R14
	assign conv_start = start_q;
	assign conv_abort = abort_q;
	assign conv_channel = chan_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			idx_q <= 3'h0;
			hit_q <= 1'b0;
			start_q <= 1'b0;
			abort_q <= 1'b0;
			chan_q <= RST_SC1[4:0];
		end else begin
			start_q <= 1'b0;
			abort_q <= sc1_wr && (state_q != ST_IDLE); // see R1
			case (state_q)
				ST_IDLE, ST_BUSY, ST_NEXT: begin
					if (sc1_wr && !trig) begin
						state_q <= ST_IDLE; // see R1 R4
					end else if (trig) begin
						state_q <= ST_BUSY; // see R1 R18
						idx_q <= 3'h0;
						hit_q <= 1'b0;
						chan_q <= first_ch; // see R12 R2
						start_q <= 1'b1;
					end else if (state_q == ST_NEXT) begin
						state_q <= ST_BUSY;
						start_q <= 1'b1;
					end else if (take_done && !last) begin
						state_q <= ST_NEXT; // see R2
						idx_q <= idx_q + 3'h1;
						hit_q <= hit_q || cmp_ok;
						chan_q <= chq_q[idx_q + 3'h1];
					end else if (take_done && cont_q) begin
						state_q <= ST_NEXT; // see R6 R18
						idx_q <= 3'h0;
						hit_q <= 1'b0;
						chan_q <= first_ch;
					end else if (take_done) begin
						state_q <= ST_IDLE; // see R6
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule : adcc_top

// ---- testbench/adcc_props.sv ----
// Checker on the converter control ports.
// Assumes the bind below reaches every adcc_top instance.
`timescale 1ns/100ps
module adcc_props
	import adcc_pkg::*;
#(
	parameter int QUEUE_MAX = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// Core and interrupt
	input wire logic conv_start,
	input wire logic [4:0] conv_channel,
	input wire logic done_irq
);
	// ==========
	// Shadow of the latest write, so answers relate to requests
	logic [15:0] wa_q;
	logic [7:0] wd_q;
	logic hw_q, bv_q, nb;
	logic [2:0] dep_q;
	assign nb = s_axi_bvalid && !bv_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{wa_q, wd_q, hw_q, bv_q, dep_q} <= 29'h0;
		end else begin
			bv_q <= s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
				wa_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				wd_q <= s_axi_wdata[7:0];
			if (nb && wa_q == ADDR_SC2)
				hw_q <= wd_q[SC2_HWT];
			if (nb && wa_q == ADDR_SC4)
				dep_q <= wd_q[2:0];
		end
	end
	// ==========
	// Port relations
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_sw_start;
		nb && wa_q == ADDR_SC1 && wd_q[4:0] != CH_STOP && !hw_q
			&& dep_q == 3'h0 |-> conv_start && conv_channel == wd_q[4:0];
	endproperty
	a_sw_start: assert property (p_sw_start)
		else $error("control write did not start");
	property p_hw_hold;
		nb && wa_q == ADDR_SC1 && hw_q |-> !conv_start;
	endproperty
	a_hw_hold: assert property (p_hw_hold)
		else $error("start on write in trigger mode");
	property p_stop;
		nb && wa_q == ADDR_SC1 && wd_q[4:0] == CH_STOP |->
			(!conv_start) [*4];
	endproperty
	a_stop: assert property (p_stop)
		else $error("start after stop code");
	property p_irq_clear;
		nb && wa_q == ADDR_SC1 |-> !done_irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("flag kept after control write");
	property p_start_pulse;
		conv_start |=> !conv_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start longer than one cycle");
	property p_slverr;
		nb && wa_q == 16'h0000 |-> s_axi_bresp == RESP_SLVERR;
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("unmapped write answered okay");
	property p_b_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_refuse: assert property (p_b_refuse)
		else $error("write taken under response");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
			&& s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late or wide");
endmodule : adcc_props
bind adcc_top adcc_props #(.QUEUE_MAX(QUEUE_MAX)) u_adcc_props (.*);

// ---- testbench/adcc_core_model.sv ----
// Behavioural analog converter core for the bench.
// Assumes one-cycle start and abort pulses from the control block.
`timescale 1ns/100ps
module adcc_core_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control side
	input wire logic conv_start,
	input wire logic conv_abort,
	input wire logic [4:0] conv_channel,
	input wire logic slow,
	// Answer
	output logic conv_done,
	output logic [11:0] conv_data
);
	logic busy_q;
	logic [3:0] cnt_q;
	logic [4:0] ch_q;
	// ==========
	// One conversion at a time; the code names the routed channel.
	// Data toggles outside done so stale codes never look valid.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{busy_q, cnt_q, ch_q, conv_done, conv_data} <= 23'h0;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_abort)
				busy_q <= 1'b0;
			if (conv_start) begin
				busy_q <= 1'b1;
				ch_q <= conv_channel;
				cnt_q <= slow ? 4'h9 : 4'h2;
			end else if (busy_q && !conv_abort) begin
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h0) begin
					busy_q <= 1'b0;
					conv_done <= 1'b1;
					conv_data <= {ch_q, ch_q, 2'b01};
				end
			end
		end
	end
endmodule : adcc_core_model

// ---- testbench/tb_top.sv ----
// Bench for the converter control block with a behavioural core.
// Assumes adcc_pkg, adcc_top, the core model and the bound checker.
`timescale 1ns/100ps
module tb_top;
	import adcc_pkg::*;
	// ==========
	// Signals, named as the ports they meet
	logic aclk, aresetn, hw_trigger_input, slow, done_irq;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, conv_start, conv_abort;
	logic conv_done, conv_long_sample, conv_low_power;
	logic [15:0] s_axi_awaddr, s_axi_araddr, pin_enable;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, conv_resolution;
	logic [1:0] conv_clock_select, conv_clock_div;
	logic [4:0] conv_channel;
	logic [11:0] conv_data;
	int num_errors, total_checks, seed, starts, aborts;
	localparam logic [1:0] MODES [3] = '{MODE_8, MODE_10, MODE_12};
	adcc_top u_adcc_top (.*);
	adcc_core_model u_adcc_core_model (.*);
	// Clock, quiet inputs, reset held low
	initial begin
		{aclk, aresetn, hw_trigger_input, slow} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
		{num_errors, total_checks, starts, aborts} = 128'h0;
		seed = 32'ha308;
		forever #20 aclk = ~aclk;
	end
	// Pulse counts at mid-cycle, clear of edge races
	always @(negedge aclk) begin
		starts += int'(conv_start === 1'b1);
		aborts += int'(conv_abort === 1'b1);
	end
	// ==========
	// Compare, bus tasks and expectations
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		int n;
		logic aw, w, b;
		n = 0;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (!b && n < 60) begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		check({31'h0, b}, 32'h1);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		int n;
		logic hs, v;
		n = 0;
		v = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!v && n < 60) begin
			@(negedge aclk);
			hs = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			rd_val = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (hs)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		check({31'h0, v}, 32'h1);
	endtask : rd
	// Read until a bit settles; a bit still unsettled after 200 more reads fails the check
	task automatic poll(input logic [15:0] a, input int b, input logic v);
		int n;
		n = 0;
		rd(a);
		while (rd_val[b] !== v && n < 200) begin
			rd(a);
			n++;
		end
		check({31'h0, rd_val[b]}, {31'h0, v});
	endtask : poll
	task automatic rres(output logic [31:0] r);
		rd(ADDR_RH);
		r[31:8] = rd_val[23:0];
		rd(ADDR_RL);
		r[7:0] = rd_val[7:0];
	endtask : rres
	function automatic logic [31:0] exp_res(input logic [4:0] ch,
		input logic [1:0] m);
		logic [11:0] raw;
		raw = {ch, ch, 2'b01};
		if (m == MODE_8)
			return {24'h0, raw[11:4]};
		if (m == MODE_10)
			return {22'h0, raw[11:2]};
		return {20'h0, raw};
	endfunction : exp_res
	task automatic print_verdict;
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// ==========
	// Watchdog, sized well above the whole sequence
	initial begin
		repeat (40000) @(posedge aclk);
		check(32'h0, 32'h1);
		print_verdict();
	end
	// Scenarios
	initial begin
		logic [31:0] r, c;
		logic [4:0] ch;
		logic [4:0] chs [8];
		int s0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(ADDR_SC1 + 16'(4 * i));
			check(rd_val, i == 0 ? 32'h1f : i == 1 ? 32'h08 : 32'h0);
			check({30'h0, resp}, {30'h0, RESP_OKAY});
		end
		wr(ADDR_RH, 8'hff);
		rd(ADDR_RH);
		check(rd_val, 32'h0);
		rd(16'h0000);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(16'h0000, 8'h5a);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		// Pin control reaches the pads; a write without lane 0 is dropped
		wr(ADDR_PC1, 8'h5c);
		check({30'h0, resp}, {30'h0, RESP_OKAY});
		c = $random(seed);
		wr(ADDR_PC2, c[7:0]);
		s_axi_wstrb <= 4'he;
		wr(ADDR_PC1, 8'ha3);
		s_axi_wstrb <= 4'h1;
		check({30'h0, resp}, {30'h0, RESP_OKAY});
		check({16'h0, pin_enable}, {16'h0, c[7:0], 8'h5c});
		rd(ADDR_PC2);
		check(rd_val, {24'h0, c[7:0]});
		for (int i = 0; i < 4; i++) begin
			c = $random(seed);
			c[1:0] = 2'(i);
			wr(ADDR_SC3, c[7:0]);
			check({conv_low_power, conv_clock_div, conv_long_sample,
				conv_resolution, conv_clock_select}, c[7:0]);
		end
		for (int i = 0; i < 3; i++) begin
			ch = 5'($unsigned($random(seed)) % 24);
			slow <= i[0];
			wr(ADDR_SC3, {4'h0, MODES[i], 2'h0});
			wr(ADDR_SC1, {3'h2, ch});
			poll(ADDR_SC1, 7, 1'b1);
			check({31'h0, done_irq}, 32'h1);
			rres(r);
			check(r, exp_res(ch, MODES[i]));
			rd(ADDR_SC1);
			check(rd_val, {27'h2, ch});
			check({31'h0, done_irq}, 32'h0);
			rd(ADDR_SC2);
			check(rd_val, 32'h08);
		end
		// Second write lands mid-conversion
		slow <= 1'b1;
		s0 = aborts;
		wr(ADDR_SC1, 8'h03);
		wr(ADDR_SC1, 8'h09);
		poll(ADDR_SC1, 7, 1'b1);
		rres(r);
		check(r, exp_res(5'h09, MODE_12));
		check(aborts - s0, 1);
		slow <= 1'b0;
		// Compare at both sides of the boundary, both senses
		r = exp_res(5'h05, MODE_12);
		for (int k = 0; k < 4; k++) begin
			c = r + 32'(k[1]);
			wr(ADDR_CVH, c[15:8]);
			wr(ADDR_CVL, c[7:0]);
			wr(ADDR_SC2, k[0] ? 8'h38 : 8'h28);
			wr(ADDR_SC1, 8'h05);
			poll(ADDR_SC2, 7, 1'b0);
			rd(ADDR_SC1);
			check(32'(rd_val[7]), 32'(k[0] ? r >= c : r < c));
		end
		wr(ADDR_SC2, 8'h08);
		wr(ADDR_SC1, 8'h27);
		s0 = starts;
		repeat (40) @(posedge aclk);
		check(32'(starts - s0 > 3), 32'h1);
		wr(ADDR_SC1, 8'h1f);
		s0 = starts;
		rd(ADDR_SC2);
		check(rd_val, 32'h08);
		check(starts - s0, 0);
		// Smallest and largest queue
		for (int q = 1; q < 8; q += 6) begin
			wr(ADDR_SC4, 8'(q));
			s0 = starts;
			for (int j = 0; j <= q; j++) begin
				chs[j] = 5'($unsigned($random(seed)) % 24);
				if (j == q)
					check(starts - s0, 0);
				wr(ADDR_SC1, {3'h0, chs[j]});
			end
			poll(ADDR_SC1, 7, 1'b1);
			for (int j = 0; j <= q; j++) begin
				rres(r);
				check(r, exp_res(chs[j], MODE_12));
			end
			wr(ADDR_SC1, 8'h1f);
			wr(ADDR_SC4, 8'h00);
		end
		wr(ADDR_SC2, 8'h48);
		s0 = starts;
		wr(ADDR_SC1, 8'h0b);
		check(starts - s0, 0);
		hw_trigger_input <= 1'b1;
		repeat (4) @(posedge aclk);
		hw_trigger_input <= 1'b0;
		poll(ADDR_SC1, 7, 1'b1);
		rres(r);
		check(r, exp_res(5'h0b, MODE_12));
		print_verdict();
	end
endmodule : tb_top
